/* File: logic/rx_ts_map.vh */
// Purpose: register offsets, field positions and timing constants of the time-stamp and receive slice
// Assumes: byte-wide register index on the serial link, 32-bit data words
// Notes: definitions only
`ifndef RX_TS_MAP_VH
`define RX_TS_MAP_VH
`define ADDR_TIMER_CFG 8'h84
`define ADDR_QE_CORR 8'h87
`define ADDR_START 8'h88
`define ADDR_CAPT_LO 8'h89
`define ADDR_CAPT_HI 8'h8a
`define ADDR_CAPT_FREE 8'h8b
`define ADDR_RX_LEN 8'h90
`define ADDR_RX_DATA 8'h91
`define ADDR_RX_TOTAL 8'ha0
`define ADDR_RX_BCAST 8'ha1
`define ADDR_RX_MCAST 8'ha2
`define ADDR_RX_UCAST 8'ha3
`define CFG_DEF_BIT 2
`define CFG_HALT_BIT 3
`define CMD_WRITE_BIT 14
`define TICK_NS 32'h00000010
`define START_MIN 32'h00000010
`define NS_WRAP 32'h3b9aca00
`define HEAD_LAST 6'h0f
`define WORD_LAST 6'h1f
`define BYTES_PER_WORD 11'h004
`define ZERO_WORD 32'h00000000
`endif

/* File: logic/rx_ts_regs.v */
// Purpose: serial-reached registers for timer output, pin time-stamp capture, receive readout and statistics
// Assumes: serial mode 0 link, sclk far slower than clock; receive FIFO and frame classifier outside
// Notes: one clock tick advances the nanosecond counter by 16 ns units
// Notes on behaviour
// - a correction value 0..255 is added to the phase residue to offset quantization
// - writing a start time of at least 16 arms the output; it runs once time reaches it
// - halting a running output stops it and restores the default level
// - a capture pin rising edge latches the 64-bit time stamp into two words
// - the same edge latches the free-running counter into its own word
// - head frame length, 11 bits, header included, is readable
// - each data word read returns four FIFO bytes and pops them
// - earliest byte sits in the top lane, later bytes in lower lanes
// - after a whole frame, data reads return zero until length read again
// - data readout works only while the generic serial protocol is selected
// - burst reads of the data word repeat on the same index
// - total received frame count increments for every frame
// - broadcast frame count increments for good and errored frames
// - multicast frame count increments for good and errored frames not also flagged broadcast
// - unicast frame count kept, reset to zero
// - nanosecond counter advances sixteen units per tick, free-running counter one
// - halt bit acts on writing one and reads back as zero
`timescale 1ns/100ps
`default_nettype none
`include "rx_ts_map.vh"
module rx_ts_regs #(
	parameter [31:0] TIMER_HI_NS = 32'h000003e8,
	parameter [31:0] TIMER_LO_NS = 32'h000003e8
) (
	input wire clock,
	input wire rst_n,
	input wire spi_sclk,
	input wire spi_cs_n,
	input wire spi_mosi,
	output reg spi_miso,
	output reg spi_miso_oe,
	input wire capture_input_pin,
	input wire generic_spi_sel,
	input wire rx_frame_valid,
	input wire [10:0] rx_frame_length,
	input wire [31:0] rx_fifo_data,
	output reg rx_fifo_pop,
	input wire rx_frame_done,
	input wire rx_frame_bcast,
	input wire rx_frame_mcast,
	output reg periodic_timer_output
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_HEAD = 2'h1;
	localparam [1:0] ST_DATA = 2'h2;
	// pin bits: 0 sclk, 1 cs_n, 2 mosi, 3 capture, 4 protocol select
	reg [4:0] meta_reg;
	reg [4:0] sync_reg;
	reg [4:0] prev_reg;
	reg [1:0] st_reg;
	reg [5:0] bit_cnt_reg;
	reg [31:0] shift_in_reg;
	reg [31:0] tx_shift_reg;
	reg [7:0] addr_reg;
	reg write_reg;
	reg [10:0] bytes_left_reg;
	reg def_level_reg;
	reg [7:0] corr_reg;
	reg [31:0] start_reg;
	reg armed_reg;
	reg running_reg;
	reg [31:0] phase_acc_reg;
	reg [31:0] ns_reg;
	reg [31:0] sec_reg;
	reg [31:0] free_reg;
	reg [63:0] capt_stamp_reg;
	reg [31:0] capt_free_reg;
	reg [31:0] stat_reg [0:3];
	reg [31:0] rd_word;
	integer i;
	wire sclk_rise = sync_reg[0] & ~prev_reg[0];
	wire sclk_fall = ~sync_reg[0] & prev_reg[0];
	wire cs_active = ~sync_reg[1];
	wire mosi_bit = sync_reg[2];
	wire capt_rise = sync_reg[3] & ~prev_reg[3];
	wire generic_mode = sync_reg[4];
	wire head_done = (st_reg == ST_HEAD) & sclk_rise & (bit_cnt_reg == `HEAD_LAST);
	wire word_done = (st_reg == ST_DATA) & sclk_rise & (bit_cnt_reg == `WORD_LAST);
	wire [7:0] head_addr = {shift_in_reg[6:0], mosi_bit};
	// the data word keeps its index so a burst drains the FIFO
	wire [7:0] addr_step = (addr_reg == `ADDR_RX_DATA) ? addr_reg : addr_reg + 8'h01;
	wire [7:0] rd_addr = (st_reg == ST_HEAD) ? head_addr : addr_step;
	wire [31:0] wr_data = {shift_in_reg[30:0], mosi_bit};
	// header bit b sits at wr_data[b] on the 16th rise, one place above shift_in_reg
	wire load_rd = (head_done & ~wr_data[`CMD_WRITE_BIT]) | (word_done & ~write_reg);
	wire wr_fire = word_done & write_reg;
	wire halt_wr = wr_fire & (addr_reg == `ADDR_TIMER_CFG) & wr_data[`CFG_HALT_BIT];
	wire start_wr = wr_fire & (addr_reg == `ADDR_START);
	wire rx_ok = generic_mode & (bytes_left_reg != 11'h000);
	wire [10:0] len_now = rx_frame_valid ? rx_frame_length : 11'h000;
	wire pop_now = load_rd & (rd_addr == `ADDR_RX_DATA) & rx_ok;
	wire len_read = load_rd & (rd_addr == `ADDR_RX_LEN);
	wire [31:0] target = periodic_timer_output ? TIMER_HI_NS : TIMER_LO_NS;
	wire [31:0] acc_sum = phase_acc_reg + `TICK_NS;
	wire [31:0] ns_sum = ns_reg + `TICK_NS;
	wire [3:0] stat_inc;
	assign stat_inc[0] = rx_frame_done;
	assign stat_inc[1] = rx_frame_done & rx_frame_bcast;
	assign stat_inc[2] = rx_frame_done & rx_frame_mcast & ~rx_frame_bcast;
	assign stat_inc[3] = rx_frame_done & ~rx_frame_mcast & ~rx_frame_bcast;

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 5'h02;
			sync_reg <= 5'h02;
			prev_reg <= 5'h02;
		end
		else
		begin
			meta_reg <= {generic_spi_sel, capture_input_pin, spi_mosi, spi_cs_n, spi_sclk};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	always @*
	begin
		rd_word = `ZERO_WORD;
		case (rd_addr)
			`ADDR_TIMER_CFG: rd_word[`CFG_DEF_BIT] = def_level_reg;
			`ADDR_QE_CORR: rd_word = {24'h000000, corr_reg};
			`ADDR_START: rd_word = start_reg;
			`ADDR_CAPT_LO: rd_word = capt_stamp_reg[31:0];
			`ADDR_CAPT_HI: rd_word = capt_stamp_reg[63:32];
			`ADDR_CAPT_FREE: rd_word = capt_free_reg;
			`ADDR_RX_LEN: rd_word = {21'h00000, len_now};
			// reorder so the earliest byte leaves first on the wire
			`ADDR_RX_DATA: rd_word = rx_ok ? {rx_fifo_data[7:0], rx_fifo_data[15:8],
				rx_fifo_data[23:16], rx_fifo_data[31:24]} : `ZERO_WORD;
			`ADDR_RX_TOTAL: rd_word = stat_reg[0];
			`ADDR_RX_BCAST: rd_word = stat_reg[1];
			`ADDR_RX_MCAST: rd_word = stat_reg[2];
			`ADDR_RX_UCAST: rd_word = stat_reg[3];
			default: rd_word = `ZERO_WORD;
		endcase
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= ST_IDLE;
			bit_cnt_reg <= 6'h00;
			shift_in_reg <= `ZERO_WORD;
			tx_shift_reg <= `ZERO_WORD;
			addr_reg <= 8'h00;
			write_reg <= 1'b0;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end
		else
		begin
			spi_miso_oe <= cs_active;
			if (!cs_active)
			begin
				st_reg <= ST_IDLE;
				bit_cnt_reg <= 6'h00;
			end
			else
			begin
				case (st_reg)
					ST_IDLE:
					begin
						st_reg <= ST_HEAD;
						bit_cnt_reg <= 6'h00;
						shift_in_reg <= `ZERO_WORD;
					end
					ST_HEAD:
					begin
						if (sclk_rise)
						begin
							shift_in_reg <= wr_data;
							bit_cnt_reg <= bit_cnt_reg + 6'h01;
						end
						if (head_done)
						begin
							st_reg <= ST_DATA;
							bit_cnt_reg <= 6'h00;
							addr_reg <= head_addr;
							write_reg <= wr_data[`CMD_WRITE_BIT];
						end
					end
					ST_DATA:
					begin
						if (sclk_rise)
						begin
							shift_in_reg <= wr_data;
							bit_cnt_reg <= bit_cnt_reg + 6'h01;
						end
						if (word_done)
						begin
							bit_cnt_reg <= 6'h00;
							addr_reg <= addr_step;
						end
						if (sclk_fall & ~write_reg)
						begin
							spi_miso <= tx_shift_reg[31];
							tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
						end
					end
					default: st_reg <= ST_IDLE;
				endcase
				if (load_rd)
					tx_shift_reg <= rd_word;
			end
		end
	end

	// receive readout: the length read opens one frame's worth of data words
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bytes_left_reg <= 11'h000;
			rx_fifo_pop <= 1'b0;
		end
		else
		begin
			rx_fifo_pop <= pop_now;
			if (len_read)
				bytes_left_reg <= len_now;
			else if (pop_now)
				bytes_left_reg <= (bytes_left_reg > `BYTES_PER_WORD) ?
					bytes_left_reg - `BYTES_PER_WORD : 11'h000;
		end
	end

	// time base, pin capture and statistics
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ns_reg <= `ZERO_WORD;
			sec_reg <= `ZERO_WORD;
			free_reg <= `ZERO_WORD;
			capt_stamp_reg <= 64'h0000000000000000;
			capt_free_reg <= `ZERO_WORD;
			for (i = 0; i < 4; i = i + 1)
				stat_reg[i] <= `ZERO_WORD;
		end
		else
		begin
			free_reg <= free_reg + 32'h00000001;
			if (ns_sum >= `NS_WRAP)
			begin
				ns_reg <= ns_sum - `NS_WRAP;
				sec_reg <= sec_reg + 32'h00000001;
			end
			else
				ns_reg <= ns_sum;
			if (capt_rise)
			begin
				capt_stamp_reg <= {sec_reg, ns_reg};
				capt_free_reg <= free_reg;
			end
			// plain add wraps from all ones to zero
			for (i = 0; i < 4; i = i + 1)
				if (stat_inc[i])
					stat_reg[i] <= stat_reg[i] + 32'h00000001;
		end
	end

	// periodic output; phase residue carries over so odd periods average out
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			def_level_reg <= 1'b0;
			corr_reg <= 8'h00;
			start_reg <= `ZERO_WORD;
			armed_reg <= 1'b0;
			running_reg <= 1'b0;
			phase_acc_reg <= `ZERO_WORD;
			periodic_timer_output <= 1'b0;
		end
		else
		begin
			if (wr_fire & (addr_reg == `ADDR_QE_CORR))
				corr_reg <= wr_data[7:0];
			// default level is frozen once the output is armed or running
			if (wr_fire & (addr_reg == `ADDR_TIMER_CFG) & ~armed_reg & ~running_reg)
				def_level_reg <= wr_data[`CFG_DEF_BIT];
			if (start_wr)
				start_reg <= wr_data;
			if (halt_wr & (armed_reg | running_reg))
			begin
				armed_reg <= 1'b0;
				running_reg <= 1'b0;
				periodic_timer_output <= def_level_reg;
			end
			else if (start_wr & (wr_data >= `START_MIN))
			begin
				armed_reg <= 1'b1;
				running_reg <= 1'b0;
			end
			else if (armed_reg & (ns_reg >= start_reg))
			begin
				armed_reg <= 1'b0;
				running_reg <= 1'b1;
				phase_acc_reg <= `ZERO_WORD;
				periodic_timer_output <= ~def_level_reg;
			end
			else if (running_reg)
			begin
				if (acc_sum >= target)
				begin
					periodic_timer_output <= ~periodic_timer_output;
					phase_acc_reg <= acc_sum + {24'h000000, corr_reg} - target;
				end
				else
					phase_acc_reg <= acc_sum;
			end
			else if (~armed_reg)
				periodic_timer_output <= def_level_reg;
		end
	end
endmodule
`default_nettype wire

/* File: tb/rx_ts_properties.sv */
// Purpose: port-level properties of the timer, capture and receive slice
// Assumes: one clock domain, asynchronous active-low reset
// Notes: pop and miso bounds rely on sclk halves of ten clocks
`timescale 1ns/100ps
`default_nettype none
module rx_ts_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	input wire logic capture_input_pin,
	input wire logic generic_spi_sel,
	input wire logic rx_frame_valid,
	input wire logic [10:0] rx_frame_length,
	input wire logic [31:0] rx_fifo_data,
	input wire logic rx_fifo_pop,
	input wire logic rx_frame_done,
	input wire logic rx_frame_bcast,
	input wire logic rx_frame_mcast,
	input wire logic periodic_timer_output
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence pop_s;
		rx_fifo_pop;
	endsequence
	sequence cs_idle_s;
		spi_cs_n [*6];
	endsequence
	sequence cs_busy_s;
		!spi_cs_n [*6];
	endsequence
	reset_idle_a: assert property ($rose(rst_n) |-> !periodic_timer_output && !rx_fifo_pop)
		else $error("timer or pop active after reset");
	pop_single_a: assert property (pop_s |=> !rx_fifo_pop [*8])
		else $error("pop wider than one word");
	pop_frame_a: assert property (pop_s |-> spi_sclk && !spi_cs_n)
		else $error("pop outside a word load");
	pop_generic_a: assert property (pop_s |-> generic_spi_sel)
		else $error("pop without generic protocol");
	oe_idle_a: assert property (cs_idle_s |-> !spi_miso_oe)
		else $error("miso driven while deselected");
	oe_drive_a: assert property (cs_busy_s |-> spi_miso_oe)
		else $error("miso not driven while selected");
	miso_fall_a: assert property ($changed(spi_miso) && !spi_cs_n |-> !spi_sclk)
		else $error("miso moved while sclk high");
	timer_phase_a: assert property ($changed(periodic_timer_output) && spi_cs_n |=> $stable(periodic_timer_output))
		else $error("timer phase shorter than two ticks");
endmodule
bind rx_ts_regs rx_ts_properties rx_ts_properties_i (.*);
`default_nettype wire

/* File: tb/spi_host.sv */
// Purpose: host side of the serial register link, mode 0, MSB first
// Assumes: each sclk half is ten system clock falls, 160 ns period
// Notes: mosi is inverted on release so a stale bit never looks valid
`timescale 1ns/100ps
`default_nettype none
module spi_host (
	input wire logic clock,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	logic [31:0] got [0:7];
	initial {sclk, cs_n, mosi} = 3'b010;
	task automatic half;
		repeat (10) @(negedge clock);
	endtask
	task automatic shift(input logic [31:0] v, input int nb, output logic [31:0] r);
		r = 32'h0;
		for (int i = nb - 1; i >= 0; i--)
		begin
			mosi = v[i];
			half();
			sclk = 1'b1;
			r = {r[30:0], miso};
			half();
			sclk = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] idx, input logic wr, input logic [31:0] wd, input int nw);
		logic [31:0] r;
		cs_n = 1'b0;
		half();
		shift({17'h0, wr, 6'h0, idx}, 16, r);
		for (int k = 0; k < nw; k++)
		begin
			shift(wd, 32, r);
			got[k] = r;
		end
		half();
		cs_n = 1'b1;
		mosi = ~mosi;
		half();
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_rx_ts_regs.sv */
// Purpose: self-checking bench for the timer, capture and receive slice
// Assumes: host model drives the link, upstream FIFO is modelled here
// Notes: phases shortened to 64 so one phase is four ticks
`timescale 1ns/100ps
`default_nettype none
`define chk(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rx_ts_regs;
	logic clock, rst_n, sclk, cs_n, mosi, dmiso, moe, capt, gsel, fvalid, pop, fdone, bcast, mcast, tout;
	logic [10:0] flen;
	logic [31:0] ptr = 32'h0;
	// an undriven miso shows the inverse of its last value so a stale bit never passes
	wire logic miso = moe ? dmiso : ~dmiso;
	int n_mismatch = 0;
	int cmp_count = 0;
	int n;
	// upstream keeps byte 0 in the low lane
	wire logic [31:0] fdata = 32'h03020100 + ptr * 32'h04040404;
	rx_ts_regs #(.TIMER_HI_NS(32'h00000040), .TIMER_LO_NS(32'h00000040)) rx_ts_regs_i (.clock(clock), .rst_n(rst_n),
		.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(dmiso), .spi_miso_oe(moe), .capture_input_pin(capt),
		.generic_spi_sel(gsel), .rx_frame_valid(fvalid), .rx_frame_length(flen), .rx_fifo_data(fdata), .rx_fifo_pop(pop),
		.rx_frame_done(fdone), .rx_frame_bcast(bcast), .rx_frame_mcast(mcast), .periodic_timer_output(tout));
	spi_host spi_host_i (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(negedge clock)
		if (pop)
			ptr <= ptr + 32'h1;
	task automatic close_out;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic next_edge(output int cnt);
		logic v;
		v = tout;
		cnt = 0;
		while (tout === v && cnt < 200)
		begin
			@(negedge clock);
			cnt++;
		end
	endtask
	task automatic t_regs;
		spi_host_i.frame(8'h89, 1'b1, 32'hffffffff, 1);
		spi_host_i.frame(8'h87, 1'b1, 32'h0000000f, 1);
		spi_host_i.frame(8'h87, 1'b0, 32'h0, 3);
		`chk(spi_host_i.got[0], 32'h0000000f)
		`chk(spi_host_i.got[2], 32'h0)
		spi_host_i.frame(8'h8f, 1'b0, 32'h0, 2);
		`chk(spi_host_i.got[0], 32'h0)
		`chk(spi_host_i.got[1], 32'h0)
		$display("t_regs done");
	endtask
	task automatic t_stats;
		for (int k = 0; k < 4; k++)
		begin
			{bcast, mcast} = 2'(k);
			fdone = 1'b1;
			@(negedge clock);
			fdone = 1'b0;
			@(negedge clock);
		end
		spi_host_i.frame(8'ha0, 1'b0, 32'h0, 4);
		`chk(spi_host_i.got[0], 32'h4)
		`chk(spi_host_i.got[1], 32'h2)
		`chk(spi_host_i.got[2], 32'h1)
		`chk(spi_host_i.got[3], 32'h1)
		$display("t_stats done");
	endtask
	task automatic t_rx;
		fvalid = 1'b1;
		flen = 11'h00a;
		spi_host_i.frame(8'h90, 1'b0, 32'h0, 5);
		`chk(spi_host_i.got[0], 32'h0000000a)
		for (int k = 1; k < 4; k++)
			`chk(spi_host_i.got[k], 32'h00010203 + (k - 1) * 32'h04040404)
		`chk(spi_host_i.got[4], 32'h0)
		`chk(ptr, 32'h3)
		gsel = 1'b0;
		spi_host_i.frame(8'h90, 1'b0, 32'h0, 2);
		`chk(spi_host_i.got[1], 32'h0)
		`chk(ptr, 32'h3)
		gsel = 1'b1;
		fvalid = 1'b0;
		$display("t_rx done");
	endtask
	task automatic t_capture;
		capt = 1'b1;
		repeat (6) @(negedge clock);
		capt = 1'b0;
		spi_host_i.frame(8'h89, 1'b0, 32'h0, 3);
		`chk(spi_host_i.got[1], 32'h0)
		`chk(spi_host_i.got[0], spi_host_i.got[2] << 4)
		`chk(spi_host_i.got[2] == 32'h0, 1'b0)
		$display("t_capture done");
	endtask
	task automatic t_timer;
		spi_host_i.frame(8'h87, 1'b1, 32'h0, 1);
		spi_host_i.frame(8'h88, 1'b1, 32'h8, 1);
		next_edge(n);
		`chk(n, 200)
		spi_host_i.frame(8'h88, 1'b1, 32'h10, 1);
		next_edge(n);
		next_edge(n);
		`chk(n, 4)
		spi_host_i.frame(8'h84, 1'b1, 32'h8, 1);
		next_edge(n);
		`chk(tout, 1'b0)
		`chk(n, 200)
		spi_host_i.frame(8'h84, 1'b0, 32'h0, 1);
		`chk(spi_host_i.got[0][3], 1'b0)
		spi_host_i.frame(8'h88, 1'b1, 32'h10, 1);
		next_edge(n);
		`chk(n < 200, 1'b1)
		// residue 15 per phase: after the first two phases the next fifteen last three ticks each, then one lasts four
		spi_host_i.frame(8'h87, 1'b1, 32'h0000000f, 1);
		spi_host_i.frame(8'h88, 1'b1, 32'h10, 1);
		next_edge(n);
		next_edge(n);
		`chk(n, 3)
		$display("t_timer done");
	endtask
	initial
	begin
		{rst_n, capt, fvalid, fdone, bcast, mcast} = 6'h00;
		gsel = 1'b1;
		flen = 11'h000;
		repeat (8) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		t_regs();
		t_stats();
		t_rx();
		t_capture();
		t_timer();
		close_out();
	end
	initial
	begin
		#400000;
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
